/* File: common/lnb_defs.svh */
`ifndef LNB_DEFS_SVH
`define LNB_DEFS_SVH

// Register offsets
`define LNB_CTRL_OFFSET 8'h01
`define LNB_STATUS_OFFSET 8'h02

// Control register fields and reset value
`define LNB_CTRL_RESET 8'h40
`define LNB_BIT_TONE_DOUBLE 0
`define LNB_BIT_SW_LIMIT 2
`define LNB_BIT_FREQ_HALF 3
`define LNB_BIT_TIMER 4
`define LNB_BIT_TONE_INT 6
`define LNB_BIT_I2C_CON 7

// Status register fields
`define LNB_BIT_LEVEL_OK 0
`define LNB_BIT_OC_ACTIVE 1
`define LNB_BIT_THERMAL 2
`define LNB_BIT_FAULT 3

// Timing in its own units
`define LNB_CLOCK_HZ 10000000
`define LNB_TICK_US 1000
`define LNB_TON_SHORT_MS 4
`define LNB_TOFF_SHORT_MS 128
`define LNB_TON_LONG_MS 8
`define LNB_TOFF_LONG_MS 256
`define LNB_TONE_HZ 22000

// Derived cycle counts
`define LNB_TICK_CYCLES ((`LNB_CLOCK_HZ / 1000000) * `LNB_TICK_US)
`define LNB_TONE_HALF_CYCLES (`LNB_CLOCK_HZ / (2 * `LNB_TONE_HZ))

`endif

/* File: common/lnb_pkg.sv */
`default_nettype none
package lnb_pkg;

  // Hiccup timer states, one-hot
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HOLD = 3'b010,
    ST_OFF = 3'b100
  } hiccup_state_t;

  // Analog indications arriving on pins
  typedef struct packed {
    logic overcurrent;
    logic temp_high;
    logic temp_low_ok;
    logic output_level_ok;
    logic enable_pin;
    logic tone_gate_input;
  } pin_in_t;

endpackage
`default_nettype wire

/* File: hdl/lnb_hiccup_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lnb_defs.svh"
module lnb_hiccup_timer #(
  parameter int TICK_CYCLES = `LNB_TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Protection inputs
  input wire logic i_overcurrent,
  input wire logic i_long_timing,
  // Converter control
  output logic o_converter_on,
  output logic o_trip
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  lnb_pkg::hiccup_state_t state_reg, state_next;
  logic [TW-1:0] div_reg, div_next;
  logic [8:0] ms_reg, ms_next;
  logic trip_reg, trip_next;
  logic tick;
  logic [8:0] on_ms;
  logic [8:0] off_ms;

  // Millisecond tick and selected period pair
  assign tick = (div_reg == TW'(TICK_CYCLES - 1));
  assign on_ms = i_long_timing ? 9'(`LNB_TON_LONG_MS) : 9'(`LNB_TON_SHORT_MS);
  assign off_ms = i_long_timing ? 9'(`LNB_TOFF_LONG_MS) : 9'(`LNB_TOFF_SHORT_MS);

  // Next state; divider and count restart on every new episode
  always_comb begin
    state_next = state_reg;
    div_next = tick ? '0 : div_reg + 1'b1;
    ms_next = ms_reg + {8'h00, tick};
    trip_next = 1'b0;
    case (state_reg)
      lnb_pkg::ST_RUN: begin
        if (i_overcurrent) begin
          state_next = lnb_pkg::ST_HOLD;
          div_next = '0;
          ms_next = 9'h000;
        end
      end
      lnb_pkg::ST_HOLD: begin
        if (!i_overcurrent) begin
          state_next = lnb_pkg::ST_RUN;
        end else if (tick && (ms_reg == on_ms - 9'h001)) begin
          state_next = lnb_pkg::ST_OFF;
          div_next = '0;
          ms_next = 9'h000;
          trip_next = 1'b1;
        end
      end
      lnb_pkg::ST_OFF: begin
        if (tick && (ms_reg == off_ms - 9'h001)) begin
          state_next = lnb_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = lnb_pkg::ST_RUN;
      end
    endcase
  end

  // State registers
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= lnb_pkg::ST_RUN;
      div_reg <= '0;
      ms_reg <= 9'h000;
      trip_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      div_reg <= div_next;
      ms_reg <= ms_next;
      trip_reg <= trip_next;
    end
  end

  assign o_converter_on = (state_reg != lnb_pkg::ST_OFF);
  assign o_trip = trip_reg;

  // Trip pulse marks the hold-to-off step
  trip_step_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_trip |-> (state_reg == lnb_pkg::ST_OFF) && ($past(state_reg) == lnb_pkg::ST_HOLD))
    else $error("trip without hold end");
  // Overcurrent going away ends the hold at once
  hold_exit_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_reg == lnb_pkg::ST_HOLD) && !i_overcurrent |=> state_reg == lnb_pkg::ST_RUN)
    else $error("hold did not end");
  // Off period ends in a retry
  off_retry_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_reg == lnb_pkg::ST_OFF) && tick && (ms_reg == off_ms - 9'h001) |=> o_converter_on)
    else $error("no retry after off period");
endmodule // lnb_hiccup_timer
`default_nettype wire

/* File: hdl/lnb_protect_tone_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lnb_defs.svh"
module lnb_protect_tone_ctrl #(
  parameter int TICK_CYCLES = `LNB_TICK_CYCLES,
  parameter int TONE_HALF = `LNB_TONE_HALF_CYCLES
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Asynchronous indications from pins and comparators
  input wire lnb_pkg::pin_in_t i_pins,
  // Register port behind the serial slave
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Power stage controls
  output logic o_output_enable,
  output logic o_converter_on,
  output logic o_boost_half_freq,
  output logic o_switch_limit_5x,
  // Fault line and tone
  output logic o_fault_n,
  output logic o_tone_out
);
  localparam int PW = $bits(lnb_pkg::pin_in_t);
  localparam int CW = $clog2(TONE_HALF + 1);

  logic [PW-1:0] s1_reg, s2_reg, s3_reg;
  logic [PW-1:0] filt_reg, filt_next;
  lnb_pkg::pin_in_t pin;

  // Three-stage synchroniser; a level counts once stages two and three agree
  generate
    for (genvar g = 0; g < PW; g++) begin : g_sync
      always_comb begin
        filt_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : filt_reg[g];
      end
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
    end else begin
      s1_reg <= i_pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  assign pin = lnb_pkg::pin_in_t'(filt_reg);

  // Control register and read port
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [7:0] status_value;
  logic ctrl_sel;
  logic status_sel;
  logic status_read;

  // Hiccup timer outputs
  logic conv_on;
  logic oc_trip;

  // Thermal, fault and enable history
  logic thermal_reg, thermal_next;
  logic fault_reg, fault_next;
  logic en_prev_reg, en_prev_next;
  logic out_en_reg, out_en_next;
  logic thermal_entry;
  logic fault_set;
  logic clear_by_read;
  logic clear_by_pin;

  assign ctrl_sel = (i_reg_addr == `LNB_CTRL_OFFSET);
  assign status_sel = (i_reg_addr == `LNB_STATUS_OFFSET);
  assign status_read = i_reg_rd && status_sel;

  // Status word; unused bits read zero
  always_comb begin
    status_value = 8'h00;
    status_value[`LNB_BIT_LEVEL_OK] = pin.output_level_ok;
    status_value[`LNB_BIT_OC_ACTIVE] = ~conv_on;
    status_value[`LNB_BIT_THERMAL] = thermal_reg;
    status_value[`LNB_BIT_FAULT] = fault_reg;
  end

  // Register access never looks at protection state, so it runs on in shutdown
  always_comb begin
    ctrl_next = ctrl_reg;
    if (i_reg_wr && ctrl_sel) begin
      ctrl_next = i_reg_wdata;
    end
    rdata_next = rdata_reg;
    rvalid_next = i_reg_rd;
    if (i_reg_rd) begin
      if (ctrl_sel) begin
        rdata_next = ctrl_reg;
      end else if (status_sel) begin
        rdata_next = status_value;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_reg <= `LNB_CTRL_RESET;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_reg_rvalid = rvalid_reg;
  assign o_boost_half_freq = ctrl_reg[`LNB_BIT_FREQ_HALF];
  assign o_switch_limit_5x = ctrl_reg[`LNB_BIT_SW_LIMIT];

  // Hiccup timing
  lnb_hiccup_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_hiccup (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_overcurrent(pin.overcurrent),
    .i_long_timing(ctrl_reg[`LNB_BIT_TIMER]),
    .o_converter_on(conv_on),
    .o_trip(oc_trip)
  );

  // Thermal hysteresis, fault latch and output gating
  assign thermal_entry = pin.temp_high && !thermal_reg;
  assign fault_set = oc_trip || thermal_entry;
  assign clear_by_read = ctrl_reg[`LNB_BIT_I2C_CON] && status_read;
  assign clear_by_pin = !ctrl_reg[`LNB_BIT_I2C_CON] && pin.enable_pin && !en_prev_reg;

  always_comb begin
    thermal_next = thermal_reg;
    if (pin.temp_high) begin
      thermal_next = 1'b1;
    end else if (pin.temp_low_ok) begin
      thermal_next = 1'b0;
    end
    // Set wins over a clear landing in the same cycle
    fault_next = fault_reg;
    if (fault_set) begin
      fault_next = 1'b1;
    end else if (clear_by_read || clear_by_pin) begin
      fault_next = 1'b0;
    end
    en_prev_next = pin.enable_pin;
    out_en_next = conv_on && !thermal_reg;
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      thermal_reg <= 1'b0;
      fault_reg <= 1'b0;
      en_prev_reg <= 1'b0;
      out_en_reg <= 1'b0;
    end else begin
      thermal_reg <= thermal_next;
      fault_reg <= fault_next;
      en_prev_reg <= en_prev_next;
      out_en_reg <= out_en_next;
    end
  end

  assign o_fault_n = ~fault_reg;
  assign o_output_enable = out_en_reg;
  assign o_converter_on = conv_on;

  // Tone path; generator phase starts fresh on each envelope so bursts are clean
  logic [CW-1:0] tone_cnt_reg, tone_cnt_next;
  logic tone_phase_reg, tone_phase_next;
  logic tone_reg, tone_next;
  logic tone_internal;

  assign tone_internal = ctrl_reg[`LNB_BIT_TONE_INT];

  always_comb begin
    tone_cnt_next = tone_cnt_reg;
    tone_phase_next = tone_phase_reg;
    if (!pin.tone_gate_input) begin
      tone_cnt_next = '0;
      tone_phase_next = 1'b1;
    end else if (tone_cnt_reg == CW'(TONE_HALF - 1)) begin
      tone_cnt_next = '0;
      tone_phase_next = ~tone_phase_reg;
    end else begin
      tone_cnt_next = tone_cnt_reg + 1'b1;
    end
    // External mode follows the pin edge for edge when each level lasts two or more cycles, including 44 kHz
    if (tone_internal) begin
      tone_next = pin.tone_gate_input && tone_phase_reg;
    end else begin
      tone_next = pin.tone_gate_input;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      tone_cnt_reg <= '0;
      tone_phase_reg <= 1'b1;
      tone_reg <= 1'b0;
    end else begin
      tone_cnt_reg <= tone_cnt_next;
      tone_phase_reg <= tone_phase_next;
      tone_reg <= tone_next;
    end
  end

  assign o_tone_out = tone_reg;

  // Enable pin low then high, with no new fault
  sequence en_cycle_s;
    !pin.enable_pin ##1 pin.enable_pin;
  endsequence

  fault_set_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    fault_set |=> !o_fault_n)
    else $error("fault line not pulled low");
  fault_hold_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    !o_fault_n && !clear_by_read && !clear_by_pin |=> !o_fault_n)
    else $error("fault released without clear");
  read_clear_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    ctrl_reg[`LNB_BIT_I2C_CON] && status_read && !fault_set |=> o_fault_n)
    else $error("status read did not release fault");
  pin_clear_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    en_cycle_s ##0 (!ctrl_reg[`LNB_BIT_I2C_CON] && !fault_set) |=> o_fault_n)
    else $error("enable cycle did not release fault");
  thermal_off_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    pin.temp_high |-> ##2 !o_output_enable)
    else $error("output on above thermal limit");
  thermal_stay_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    thermal_reg && !pin.temp_low_ok |=> thermal_reg)
    else $error("thermal cleared early");
  tone_quiet_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    !pin.tone_gate_input |=> !o_tone_out)
    else $error("tone while gate low");
  tone_pass_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    !tone_internal |=> o_tone_out == $past(pin.tone_gate_input))
    else $error("external tone not followed");
  level_bit_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    status_read |=> o_reg_rvalid && (o_reg_rdata[0] == $past(pin.output_level_ok)))
    else $error("level bit wrong");
endmodule // lnb_protect_tone_ctrl
`default_nettype wire

/* File: sim/lnb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lnb_host_model (
  // Clock
  input wire logic i_clock,
  // Register answers
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_rvalid,
  // Pins and register requests toward the block
  output var lnb_pkg::pin_in_t o_pins,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata
);
  // Idle: enabled, cool, level good, no tone
  initial begin
    o_pins = 6'h0E;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end

  // Idle bus shows the inverse, so a stale value is never read by luck
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    #1;
    o_reg_wr = 1'b1;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(posedge i_clock);
    #1;
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask

  // A read of the status register also clears the fault under register control
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    #1;
    o_reg_rd = 1'b1;
    o_reg_addr = a;
    @(posedge i_clock);
    #1;
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    d = i_reg_rvalid ? i_reg_rdata : 8'hXX;
  endtask

  // Fault clear without register control: enable low, then high
  task automatic enable_cycle();
    @(posedge i_clock);
    #1;
    o_pins.enable_pin = 1'b0;
    repeat (6) @(posedge i_clock);
    #1;
    o_pins.enable_pin = 1'b1;
  endtask

  // External tone as a square wave on the gate input
  task automatic square(input int half, input int n);
    repeat (2 * n) begin
      @(posedge i_clock);
      #1;
      o_pins.tone_gate_input = ~o_pins.tone_gate_input;
      repeat (half - 1) @(posedge i_clock);
    end
  endtask
endmodule // lnb_host_model
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  wire lnb_pkg::pin_in_t pins;
  wire logic reg_wr, reg_rd, rvalid, oe, conv, half_freq, limit_5x, fault_n, tone;
  wire logic [7:0] reg_addr, reg_wdata, rdata;
  int errors = 0;
  int num_checks = 0;
  int rises = 0;
  logic tone_q = 1'b0;
  logic [7:0] v;
  int n;

  // 10 MHz clock
  always #50 i_clock = ~i_clock;

  // Short counts: 1 ms tick is 10 cycles, tone half period 5 cycles
  lnb_protect_tone_ctrl #(.TICK_CYCLES(10), .TONE_HALF(5)) dut (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_pins(pins),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_output_enable(oe), .o_converter_on(conv),
    .o_boost_half_freq(half_freq), .o_switch_limit_5x(limit_5x), .o_fault_n(fault_n), .o_tone_out(tone));

  lnb_host_model host (
    .i_clock(i_clock), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid), .o_pins(pins),
    .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata));

  // Tone rising edges, counted for frequency checks
  always @(posedge i_clock) begin
    tone_q <= tone;
    if (tone === 1'b1 && tone_q === 1'b0) begin
      rises++;
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Bounded wait for an output level; sel 0 converter, 1 fault, 2 enable
  task automatic await(input int sel, input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while ((sel == 0 ? conv : sel == 1 ? fault_n : oe) !== lvl && cnt < lim) begin
      @(posedge i_clock);
      #1;
      cnt++;
    end
    if (cnt >= lim) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, cnt, lim);
      conclude();
    end
  endtask

  task automatic t_defaults();
    host.rd(8'h01, v);
    check(v, 8'h40);
    check({half_freq, limit_5x, fault_n}, 3'h1);
    host.rd(8'h07, v);
    check(v, 8'h00);
    host.wr(8'h01, 8'h4C);
    host.rd(8'h01, v);
    check(v, 8'h4C);
    check({half_freq, limit_5x}, 2'h3);
    host.wr(8'h01, 8'h40);
    $display("test defaults done");
  endtask

  // Hiccup with both timing pairs; long pair runs under register control
  task automatic t_hiccup(input logic long_pair);
    int on_t, off_t;
    on_t = long_pair ? 80 : 40;
    off_t = long_pair ? 2560 : 1280;
    host.wr(8'h01, long_pair ? 8'hD0 : 8'h40);
    // A short episode must not trip, and the next one counts from zero
    host.o_pins.overcurrent = 1'b1;
    repeat (on_t - 10) @(posedge i_clock);
    #1;
    host.o_pins.overcurrent = 1'b0;
    repeat (on_t) @(posedge i_clock);
    #1;
    check(conv, 1'b1);
    host.o_pins.overcurrent = 1'b1;
    await(0, 1'b0, 200, n);
    check(8'(n >= on_t && n <= on_t + 10), 8'h01);
    host.o_pins.overcurrent = 1'b0;
    @(posedge i_clock);
    #1;
    check(fault_n, 1'b0);
    host.rd(8'h02, v);
    check(v[3:1], 3'h5);
    check(fault_n, long_pair);
    await(0, 1'b1, 3000, n);
    check(8'(n >= off_t - 8 && n <= off_t + 2), 8'h01);
    if (!long_pair) begin
      host.enable_cycle();
      await(1, 1'b1, 10, n);
    end
    host.wr(8'h01, 8'h40);
    $display("test hiccup done");
  endtask

  task automatic t_thermal();
    host.o_pins.temp_high = 1'b1;
    host.o_pins.temp_low_ok = 1'b0;
    await(2, 1'b0, 10, n);
    check(fault_n, 1'b0);
    host.o_pins.temp_high = 1'b0;
    repeat (20) @(posedge i_clock);
    #1;
    check(oe, 1'b0);
    host.rd(8'h02, v);
    check(v[2], 1'b1);
    host.o_pins.temp_low_ok = 1'b1;
    await(2, 1'b1, 10, n);
    check(fault_n, 1'b0);
    host.enable_cycle();
    await(1, 1'b1, 10, n);
    $display("test thermal done");
  endtask

  task automatic t_level();
    host.o_pins.output_level_ok = 1'b0;
    repeat (6) @(posedge i_clock);
    host.rd(8'h02, v);
    check(v[0], 1'b0);
    host.o_pins.output_level_ok = 1'b1;
    repeat (6) @(posedge i_clock);
    host.rd(8'h02, v);
    check(v[0], 1'b1);
    $display("test level done");
  endtask

  task automatic t_tone();
    host.o_pins.tone_gate_input = 1'b1;
    rises = 0;
    repeat (60) @(posedge i_clock);
    #1;
    check(8'(rises >= 5 && rises <= 7), 8'h01);
    host.o_pins.tone_gate_input = 1'b0;
    repeat (6) @(posedge i_clock);
    #1;
    rises = 0;
    repeat (30) @(posedge i_clock);
    #1;
    check(8'(rises), 8'h00);
    check(tone, 1'b0);
    host.wr(8'h01, 8'h01);
    rises = 0;
    host.square(3, 10);
    repeat (8) @(posedge i_clock);
    #1;
    check(8'(rises), 8'h0A);
    host.wr(8'h01, 8'h00);
    rises = 0;
    host.square(114, 2);
    repeat (8) @(posedge i_clock);
    #1;
    check(8'(rises), 8'h02);
    host.wr(8'h01, 8'h40);
    $display("test tone done");
  endtask

  // Reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge i_clock);
    #1;
    i_resetn = 1'b1;
    t_defaults();
    t_hiccup(1'b0);
    t_hiccup(1'b1);
    t_thermal();
    t_level();
    t_tone();
    conclude();
  end
endmodule // testbench
`default_nettype wire
